// [hw/hsps_pkg.sv]
// Shared constants, register map and state encoding of the hot-swap power sequencer
package hsps_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    // Breaker time constant, trip needs more than this
    localparam int CB_TC_NS = 16000;
    localparam int CB_CYC = (CB_TC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Host reset glitch rejection width
    localparam int GLITCH_NS = 40;
    localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Power-on delay and reset pulse settings, in time base ticks (ms)
    localparam logic [11:0] IVL_MS_25 = 12'h019;
    localparam logic [11:0] IVL_MS_50 = 12'h032;
    localparam logic [11:0] IVL_MS_100 = 12'h064;
    localparam logic [11:0] IVL_MS_200 = 12'h0C8;
    // Watchdog settings, in ticks (ms)
    localparam logic [11:0] WD_MS_800 = 12'h320;
    localparam logic [11:0] WD_MS_1600 = 12'h640;
    localparam logic [11:0] WD_MS_3200 = 12'hC80;

    // Register map
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;

    // Control register fields
    localparam int CTRL_W = 13;
    localparam int CTRL_PON_LSB = 0;
    localparam int CTRL_RST_LSB = 2;
    localparam int CTRL_WD_LSB = 4;
    localparam int CTRL_AUXA_HOST = 6;
    localparam int CTRL_AUXB_HOST = 7;
    localparam int CTRL_AUXA_OV = 8;
    localparam int CTRL_AUXB_OV = 9;
    localparam int CTRL_CB_LSB = 10;
    localparam int CTRL_SINGLE = 12;
    localparam logic [12:0] CTRL_RST_VAL = 13'h0000;

    // Status register fields
    localparam int STS_GATE = 0;
    localparam int STS_RESET = 1;
    localparam int STS_HEALTHY = 2;
    localparam int STS_FAULT = 3;
    localparam int STS_WDOG = 4;
    localparam int STS_HOST_OK = 5;
    localparam int STS_CARD_OK = 6;
    localparam int STS_ENUM = 7;

    // Sequencer states
    typedef enum logic [2:0] {
        HSPS_OFF = 3'b000,
        HSPS_DELAY = 3'b001,
        HSPS_RAMP = 3'b010,
        HSPS_RESET = 3'b011,
        HSPS_RUN = 3'b100,
        HSPS_HRST = 3'b101,
        HSPS_FAULT = 3'b110
    } hsps_state_type;
endpackage

// [hw/hsps_sync.sv]
// Two-stage synchroniser for a group of comparator levels
`timescale 1ns/100ps
`default_nettype none
module hsps_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [hw/hsps_sequencer.sv]
// Hot-swap card power sequencer, breaker, reset control and watchdog
//
// Behaviour
// - At power-up hold resets, gates off, unhealthy
// - Release resets after stable card supply, interval
// - All card monitors good with gates on drives health low
// - Board deselect: gates off, unhealthy, resets asserted
// - Ejector open raises notice; host deselects board
// - Sequence halts while host supplies are bad
// - Card low voltage resets, gates stay on
// - Aux monitors assignable host/card side, ANDed
// - Aux monitors flag under- or over-voltage
// - Watchdog interval 0.8, 1.6 or 3.2 s
// - Watchdog restarts on address, acknowledge, select edge
// - Breaker trips after overcurrent above 16 us
// - Trip asserts fault and turns gates off
// - Delay and reset width 25/50/100/200 ms
// - Resets released last when all conditions hold
// - Host reset over 40 ns starts reset cycle
// - Reset held full interval or host reset
// - Strap picks 3.3V or 5V as valid power
`timescale 1ns/100ps
`default_nettype none
module hsps_sequencer #(
    parameter int TICK_CYCLES = hsps_pkg::TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [hsps_pkg::REG_AW-1:0] reg_addr,
    input wire logic [hsps_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hsps_pkg::REG_DW-1:0] reg_rdata,
    input wire logic host_high_rail_ok,
    input wire logic host_low_rail_sense,
    input wire logic card_low_rail_sense,
    input wire logic card_high_rail_sense,
    input wire logic aux_sense_a,
    input wire logic aux_sense_b,
    input wire logic current_sense_input,
    input wire logic board_select_n,
    input wire logic power_permit,
    input wire logic host_reset_n,
    input wire logic supply_level_strap,
    input wire logic ejector_open,
    input wire logic bus_addr_match,
    input wire logic bus_ack_drive,
    input wire logic chip_select_n,
    output logic gate_drive_low_rail,
    output logic gate_drive_high_rail,
    output logic card_reset,
    output logic card_reset_n,
    output logic card_healthy_n,
    output logic fault_n,
    output logic enum_n,
    output logic [1:0] breaker_level_sel,
    output logic watchdog_timeout
);
    import hsps_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES);

    logic [6:0] cmp_raw;
    logic [6:0] cmp_s;
    logic [CTRL_W-1:0] ctrl_q;
    logic strap_q;
    logic strap_done_q;
    logic aux_a_ok, aux_b_ok, host_base_ok, card_base_ok, host_ok, card_ok, oc;
    logic [TW-1:0] tick_q;
    logic tick;
    hsps_state_type state_q, state_d;
    logic gates_on, gates_on_d;
    logic [11:0] ivl_q;
    logic [11:0] ivl_lim;
    logic ivl_done, ivl_run;
    logic [10:0] cb_q;
    logic cb_trip;
    logic [2:0] hr_q;
    logic hr_long;
    logic rel_ok;
    logic cs_prev_q;
    logic wd_kick;
    logic [11:0] wd_q;
    logic [11:0] wd_lim;
    logic wd_flag_q;
    logic [7:0] status;

    // Comparator levels are asynchronous to clk
    assign cmp_raw = {current_sense_input, aux_sense_b, aux_sense_a, card_high_rail_sense,
                      card_low_rail_sense, host_low_rail_sense, host_high_rail_ok};
    hsps_sync #(.WIDTH(7)) u_cmp_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(cmp_raw),
        .q(cmp_s)
    );

    // Strap is caught once, at the first edge after reset release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_q <= supply_level_strap;
            strap_done_q <= 1'b1;
        end
    end

    // Monitor combination; comparator high means above its reference
    always_comb begin
        aux_a_ok = cmp_s[4] ^ ctrl_q[CTRL_AUXA_OV];
        aux_b_ok = cmp_s[5] ^ ctrl_q[CTRL_AUXB_OV];
        // Single supply: strap high counts the low rail, low the high rail
        if (ctrl_q[CTRL_SINGLE]) begin
            host_base_ok = strap_q ? cmp_s[1] : cmp_s[0];
            card_base_ok = strap_q ? cmp_s[2] : cmp_s[3];
        end else begin
            host_base_ok = cmp_s[0] & cmp_s[1];
            card_base_ok = cmp_s[2] & cmp_s[3];
        end
        host_ok = host_base_ok & (!ctrl_q[CTRL_AUXA_HOST] | aux_a_ok)
                  & (!ctrl_q[CTRL_AUXB_HOST] | aux_b_ok);
        card_ok = card_base_ok & (ctrl_q[CTRL_AUXA_HOST] | aux_a_ok)
                  & (ctrl_q[CTRL_AUXB_HOST] | aux_b_ok);
        oc = cmp_s[6];
    end

    // Free-running time base, one tick per millisecond
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_q <= '0;
        end else if (tick) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end
    assign tick = (tick_q == TW'(TICK_CYCLES - 1));

    // Breaker filter: trips only on a drop held past the time constant
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cb_q <= '0;
        end else if (!oc || !gates_on) begin
            cb_q <= '0;
        end else if (cb_q != 11'(CB_CYC)) begin
            cb_q <= cb_q + 1'b1;
        end
    end
    assign cb_trip = gates_on && oc && (cb_q == 11'(CB_CYC));

    // Host reset glitch filter counts consecutive low samples
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hr_q <= '0;
        end else if (host_reset_n) begin
            hr_q <= '0;
        end else if (hr_q != 3'(GLITCH_CYC)) begin
            hr_q <= hr_q + 1'b1;
        end
    end
    assign hr_long = !host_reset_n && (hr_q == 3'(GLITCH_CYC));

    // Interval limit follows the state that is being timed
    always_comb begin
        logic [1:0] sel;
        sel = (state_q == HSPS_DELAY) ? ctrl_q[CTRL_PON_LSB +: 2] : ctrl_q[CTRL_RST_LSB +: 2];
        case (sel)
            2'h0: ivl_lim = IVL_MS_25;
            2'h1: ivl_lim = IVL_MS_50;
            2'h2: ivl_lim = IVL_MS_100;
            default: ivl_lim = IVL_MS_200;
        endcase
    end
    assign ivl_done = (ivl_q >= ivl_lim);
    assign ivl_run = ((state_q == HSPS_DELAY) && host_ok) || (state_q == HSPS_RESET)
                     || (state_q == HSPS_HRST);

    // Interval counter restarts on each state change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ivl_q <= '0;
        end else if (state_d != state_q) begin
            ivl_q <= '0;
        end else if (ivl_run && tick && !ivl_done) begin
            ivl_q <= ivl_q + 1'b1;
        end
    end

    assign gates_on = (state_q == HSPS_RAMP) || (state_q == HSPS_RESET)
                      || (state_q == HSPS_RUN) || (state_q == HSPS_HRST);
    assign rel_ok = host_ok && !board_select_n && card_ok && power_permit && host_reset_n;

    // Sequencer; deselect wins over everything, then trip, then host loss
    always_comb begin
        state_d = state_q;
        if (board_select_n) begin
            state_d = HSPS_OFF;
        end else if (cb_trip) begin
            state_d = HSPS_FAULT;
        end else if (gates_on && (!host_ok || !power_permit)) begin
            state_d = HSPS_OFF;
        end else begin
            case (state_q)
                HSPS_OFF: begin
                    if (power_permit && host_ok) begin
                        state_d = HSPS_DELAY;
                    end
                end
                HSPS_DELAY: begin
                    if (!power_permit) begin
                        state_d = HSPS_OFF;
                    end else if (ivl_done && host_ok) begin
                        state_d = HSPS_RAMP;
                    end
                end
                HSPS_RAMP: begin
                    if (card_ok) begin
                        state_d = HSPS_RESET;
                    end
                end
                HSPS_RESET, HSPS_HRST: begin
                    if (!card_ok) begin
                        state_d = HSPS_RAMP;
                    end else if (ivl_done && rel_ok) begin
                        state_d = HSPS_RUN;
                    end
                end
                HSPS_RUN: begin
                    if (!card_ok) begin
                        state_d = HSPS_RAMP;
                    end else if (hr_long) begin
                        state_d = HSPS_HRST;
                    end
                end
                HSPS_FAULT: state_d = HSPS_FAULT;
                default: state_d = HSPS_OFF;
            endcase
        end
    end
    assign gates_on_d = (state_d == HSPS_RAMP) || (state_d == HSPS_RESET)
                        || (state_d == HSPS_RUN) || (state_d == HSPS_HRST);

    // State and pin registers; reset values hold the card safe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= HSPS_OFF;
            gate_drive_low_rail <= 1'b0;
            gate_drive_high_rail <= 1'b0;
            card_reset <= 1'b1;
            card_reset_n <= 1'b0;
            card_healthy_n <= 1'b1;
            fault_n <= 1'b1;
        end else begin
            state_q <= state_d;
            gate_drive_low_rail <= gates_on_d;
            gate_drive_high_rail <= gates_on_d;
            card_reset <= (state_d != HSPS_RUN);
            card_reset_n <= (state_d == HSPS_RUN);
            card_healthy_n <= !(gates_on_d && card_ok);
            fault_n <= (state_d != HSPS_FAULT);
        end
    end

    // Removal notice follows the ejector switch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enum_n <= 1'b1;
        end else begin
            enum_n <= !ejector_open;
        end
    end

    // Watchdog restarts on any bus sign of life
    assign wd_kick = bus_addr_match || bus_ack_drive || (chip_select_n != cs_prev_q);
    always_comb begin
        case (ctrl_q[CTRL_WD_LSB +: 2])
            2'h0: wd_lim = WD_MS_800;
            2'h1: wd_lim = WD_MS_1600;
            default: wd_lim = WD_MS_3200;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_prev_q <= 1'b1;
            wd_q <= '0;
            watchdog_timeout <= 1'b0;
        end else begin
            cs_prev_q <= chip_select_n;
            watchdog_timeout <= 1'b0;
            if (wd_kick) begin
                wd_q <= '0;
            end else if (tick) begin
                if (wd_q >= wd_lim - 12'h001) begin
                    wd_q <= '0;
                    watchdog_timeout <= 1'b1;
                end else begin
                    wd_q <= wd_q + 1'b1;
                end
            end
        end
    end

    // Sticky timeout flag; a new timeout beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wd_flag_q <= 1'b0;
        end else if (watchdog_timeout) begin
            wd_flag_q <= 1'b1;
        end else if (reg_wr && (reg_addr == REG_STATUS) && reg_wdata[STS_WDOG]) begin
            wd_flag_q <= 1'b0;
        end
    end

    // Control register write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST_VAL;
        end else if (reg_wr && (reg_addr == REG_CTRL)) begin
            ctrl_q <= reg_wdata[CTRL_W-1:0];
        end
    end
    assign breaker_level_sel = ctrl_q[CTRL_CB_LSB +: 2];

    assign status = {!enum_n, card_ok, host_ok, wd_flag_q, !fault_n, !card_healthy_n,
                     card_reset, gate_drive_low_rail};

    // Read data stand for one cycle; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_addr == REG_CTRL) begin
            reg_rdata <= {{(REG_DW - CTRL_W){1'b0}}, ctrl_q};
        end else if (reg_addr == REG_STATUS) begin
            reg_rdata <= {24'h000000, status};
        end else begin
            reg_rdata <= '0;
        end
    end

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_deselect_off;
        board_select_n |=> !gate_drive_low_rail && !gate_drive_high_rail && card_reset
                           && card_healthy_n && !card_reset_n;
    endproperty
    a_deselect_off: assert property (p_deselect_off) else $error("deselect not off");

    property p_release_ok;
        $rose(card_reset_n) |-> $past(rel_ok) && $past(ivl_done) && gate_drive_high_rail;
    endproperty
    a_release_ok: assert property (p_release_ok) else $error("reset released early");

    property p_health;
        gates_on_d && card_ok |=> !card_healthy_n;
    endproperty
    a_health: assert property (p_health) else $error("health not asserted");

    property p_host_hold;
        (state_q == HSPS_DELAY) && !host_ok && !board_select_n && power_permit
        |=> $stable(ivl_q) && (state_q == HSPS_DELAY);
    endproperty
    a_host_hold: assert property (p_host_hold) else $error("sequence ran on bad host");

    property p_card_low;
        (state_q == HSPS_RUN) && !card_ok && !rel_ok && host_ok && power_permit
        && !board_select_n && !cb_trip |=> gate_drive_low_rail && card_reset;
    endproperty
    a_card_low: assert property (p_card_low) else $error("card low handled wrong");

    property p_breaker_time;
        $fell(fault_n) |-> $past(oc, 1) && $past(cb_q) == 11'(CB_CYC);
    endproperty
    a_breaker_time: assert property (p_breaker_time) else $error("trip timing wrong");

    property p_trip_off;
        cb_trip && !board_select_n |=> !fault_n && !gate_drive_low_rail && !gate_drive_high_rail;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("trip not acted on");

    property p_glitch;
        (state_q == HSPS_RUN) && card_ok && rel_ok ##1 !host_reset_n[*4] ##1 host_reset_n
        |-> (state_q == HSPS_RUN) || !rel_ok || !card_ok;
    endproperty
    a_glitch: assert property (p_glitch) else $error("glitch started reset");

    property p_hrst_hold;
        (state_q == HSPS_HRST) && (!ivl_done || !host_reset_n) && !board_select_n |=> card_reset;
    endproperty
    a_hrst_hold: assert property (p_hrst_hold) else $error("host reset cut short");

    property p_wd_kick;
        wd_kick |=> (wd_q == 12'h000) && !watchdog_timeout;
    endproperty
    a_wd_kick: assert property (p_wd_kick) else $error("watchdog not restarted");

    property p_enum;
        ejector_open |=> !enum_n;
    endproperty
    a_enum: assert property (p_enum) else $error("enum notice missing");

    c_run: cover property ((state_q == HSPS_RESET) ##1 (state_q == HSPS_RUN));
    c_trip: cover property ($fell(fault_n));
    c_hrst: cover property ((state_q == HSPS_HRST) ##1 (state_q == HSPS_RUN));
    c_wd: cover property (watchdog_timeout);
endmodule
`default_nettype wire

// [test/hsps_far_side.sv]
// Far-side model: host board-select handling and card supply rails
`timescale 1ns/100ps
`default_nettype none
module hsps_far_side #(
    parameter int RAMP_CYC = 20,
    parameter int EJECT_CYC = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic select_req,
    input wire logic rail_sag,
    input wire logic gate_drive_low_rail,
    input wire logic gate_drive_high_rail,
    input wire logic enum_n,
    output logic board_select_n,
    output logic card_low_rail_sense,
    output logic card_high_rail_sense
);
    int ramp_q;
    int eject_q;

    // Rails climb a while after both switches close, and collapse at once
    always_ff @(posedge clk) begin
        if (!rst_n || !(gate_drive_low_rail && gate_drive_high_rail)) begin
            ramp_q <= 0;
        end else if (ramp_q < RAMP_CYC) begin
            ramp_q <= ramp_q + 1;
        end
    end
    assign card_low_rail_sense = (ramp_q == RAMP_CYC) && !rail_sag;
    assign card_high_rail_sense = (ramp_q == RAMP_CYC) && !rail_sag;

    // Host answers an enumeration notice after a short software delay
    always_ff @(posedge clk) begin
        if (!rst_n || enum_n) begin
            eject_q <= 0;
        end else if (eject_q < EJECT_CYC) begin
            eject_q <= eject_q + 1;
        end
    end

    // Board select held by host, dropped on notice
    always_ff @(posedge clk) begin
        board_select_n <= !rst_n || !select_req || (eject_q == EJECT_CYC);
    end
endmodule
`default_nettype wire

// [test/hsps_sequencer_bench.sv]
// Self-checking bench for the hot-swap power sequencer
`timescale 1ns/100ps
`default_nettype none
module hsps_sequencer_bench;
    import hsps_pkg::*;
    localparam int SG = 0, SR = 1, SH = 2, SF = 3, SW = 4, SE = 5, SB = 6;
    logic clk, rst_n, reg_wr, reg_rd, host_high_rail_ok, host_low_rail_sense, aux_sense_a;
    logic aux_sense_b, current_sense_input, power_permit, host_reset_n, ejector_open;
    logic bus_addr_match, bus_ack_drive, chip_select_n, select_req, rail_sag, supply_level_strap;
    logic card_low_rail_sense, card_high_rail_sense, board_select_n, gate_drive_low_rail;
    logic gate_drive_high_rail, card_reset, card_reset_n, card_healthy_n, fault_n, enum_n;
    logic watchdog_timeout;
    logic [1:0] breaker_level_sel;
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata, reg_rdata, rd;
    int bad_count = 0;
    int compares = 0;
    int n;

    // Short time base keeps millisecond intervals brief
    hsps_sequencer #(.TICK_CYCLES(10)) dut (.*);
    hsps_far_side far (.*);

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            SG: pick = gate_drive_low_rail;
            SR: pick = card_reset;
            SH: pick = card_healthy_n;
            SF: pick = fault_n;
            SW: pick = watchdog_timeout;
            SE: pick = enum_n;
            default: pick = board_select_n;
        endcase
    endfunction

    // Count falling edges until the signal shows lvl, bounded by max
    task automatic wait_lvl(input int s, input logic lvl, input int max);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < max && pick(s) !== lvl);
    endtask

    task automatic seen_in(input int s, input logic lvl, input int lo, input int hi);
        wait_lvl(s, lvl, hi + 1);
        check(32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
    endtask

    task automatic hold_off(input int s, input logic lvl, input int max);
        wait_lvl(s, lvl, max);
        check(32'(pick(s)), 32'(!lvl));
    endtask

    task automatic reg_write(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk) reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) d = reg_rdata;
    endtask

    task automatic host_pulse(input int len);
        @(posedge clk) host_reset_n <= 1'b0;
        repeat (len) @(posedge clk);
        host_reset_n <= 1'b1;
    endtask

    // Watchdog restart: 0 address match, 1 acknowledge, 2 select edge
    task automatic kick(input int k);
        @(posedge clk);
        if (k == 0) bus_addr_match <= 1'b1;
        else if (k == 1) bus_ack_drive <= 1'b1;
        else chip_select_n <= !chip_select_n;
        @(posedge clk);
        bus_addr_match <= 1'b0;
        bus_ack_drive <= 1'b0;
    endtask

    task automatic note(input string s);
        $display("[DONE] %s at %0t", s, $time);
    endtask

    task automatic t_regs();
        reg_read(REG_CTRL, rd);
        check(rd, 32'(CTRL_RST_VAL));
        for (int i = 0; i < 4; i++) begin
            reg_write(REG_CTRL, 32'(i) << CTRL_CB_LSB);
            @(negedge clk);
            check(32'(breaker_level_sel), 32'(i));
        end
        reg_write(8'h08, 32'hFFFF_FFFF);
        reg_read(8'h08, rd);
        check(rd, 32'h0000_0000);
        reg_read(REG_CTRL, rd);
        check(rd, 32'h0000_0C00);
        reg_write(REG_CTRL, 32'h0000_000C);
        note("registers");
    endtask

    task automatic t_power();
        @(posedge clk) power_permit <= 1'b1;
        @(posedge clk) select_req <= 1'b1;
        hold_off(SG, 1'b1, 400);
        @(posedge clk) host_low_rail_sense <= 1'b1;
        hold_off(SG, 1'b1, 100);
        @(posedge clk) host_high_rail_ok <= 1'b0;
        hold_off(SG, 1'b1, 400);
        @(posedge clk) host_high_rail_ok <= 1'b1;
        seen_in(SG, 1'b1, 140, 165);
        check({30'h0, gate_drive_high_rail, card_reset}, 32'h3);
        seen_in(SH, 1'b0, 1, 60);
        check(32'(card_reset), 32'h1);
        seen_in(SR, 1'b0, 1980, 2030);
        check(32'(card_reset_n), 32'h1);
        reg_read(REG_STATUS, rd);
        check(rd & 32'hFFFF_FFEF, 32'h0000_0065);
        note("power up");
    endtask

    task automatic t_card();
        reg_write(REG_CTRL, 32'h0);
        @(posedge clk) rail_sag <= 1'b1;
        seen_in(SR, 1'b1, 1, 8);
        check({30'h0, gate_drive_low_rail, card_healthy_n}, 32'h3);
        @(posedge clk) rail_sag <= 1'b0;
        seen_in(SR, 1'b0, 240, 290);
        @(posedge clk) aux_sense_b <= 1'b0;
        seen_in(SR, 1'b1, 1, 8);
        @(posedge clk) aux_sense_b <= 1'b1;
        seen_in(SR, 1'b0, 240, 290);
        reg_write(REG_CTRL, 32'(1) << CTRL_AUXB_OV);
        seen_in(SR, 1'b1, 1, 8);
        @(posedge clk) aux_sense_b <= 1'b0;
        seen_in(SR, 1'b0, 240, 290);
        reg_write(REG_CTRL, (32'(1) << CTRL_AUXB_OV) | (32'(1) << CTRL_AUXA_HOST));
        @(posedge clk) aux_sense_a <= 1'b0;
        seen_in(SG, 1'b0, 1, 8);
        @(posedge clk) {aux_sense_a, host_high_rail_ok} <= 2'b10;
        hold_off(SG, 1'b1, 300);
        // Single supply with strap high: only the low rails count
        reg_write(REG_CTRL, 32'h0000_1240);
        seen_in(SG, 1'b1, 240, 280);
        seen_in(SR, 1'b0, 240, 320);
        @(posedge clk) host_high_rail_ok <= 1'b1;
        note("card monitors");
    endtask

    task automatic t_hrst();
        host_pulse(4);
        hold_off(SR, 1'b1, 30);
        host_pulse(8);
        seen_in(SR, 1'b1, 1, 12);
        seen_in(SR, 1'b0, 235, 260);
        @(posedge clk) host_reset_n <= 1'b0;
        seen_in(SR, 1'b1, 5, 8);
        hold_off(SR, 1'b0, 500);
        @(posedge clk) host_reset_n <= 1'b1;
        seen_in(SR, 1'b0, 1, 6);
        note("host reset");
    endtask

    task automatic t_eject();
        @(posedge clk) ejector_open <= 1'b1;
        seen_in(SE, 1'b0, 1, 3);
        seen_in(SB, 1'b1, 1, 10);
        seen_in(SG, 1'b0, 1, 3);
        check({29'h0, card_healthy_n, card_reset, card_reset_n}, 32'h6);
        @(posedge clk) ejector_open <= 1'b0;
        seen_in(SG, 1'b1, 240, 290);
        note("ejection");
    endtask

    task automatic t_breaker();
        @(posedge clk) current_sense_input <= 1'b1;
        hold_off(SF, 1'b0, 1500);
        @(posedge clk) current_sense_input <= 1'b0;
        hold_off(SF, 1'b0, 20);
        @(posedge clk) current_sense_input <= 1'b1;
        seen_in(SF, 1'b0, 1601, 1610);
        check(32'(gate_drive_low_rail), 32'h0);
        @(posedge clk) current_sense_input <= 1'b0;
        hold_off(SF, 1'b1, 50);
        @(posedge clk) select_req <= 1'b0;
        seen_in(SF, 1'b1, 1, 12);
        @(posedge clk) select_req <= 1'b1;
        note("breaker");
    endtask

    task automatic t_wdog();
        for (int s = 0; s < 3; s++) begin
            reg_write(REG_CTRL, 32'(s) << CTRL_WD_LSB);
            kick(0);
            if (s == 0) begin
                hold_off(SW, 1'b1, 5000);
                kick(1);
                hold_off(SW, 1'b1, 5000);
                kick(2);
            end
            seen_in(SW, 1'b1, (8000 << s) - 15, (8000 << s) + 15);
        end
        reg_read(REG_STATUS, rd);
        check(32'(rd[STS_WDOG]), 32'h1);
        reg_write(REG_STATUS, 32'(1) << STS_WDOG);
        reg_read(REG_STATUS, rd);
        check(32'(rd[STS_WDOG]), 32'h0);
        note("watchdog");
    endtask

    task automatic report_and_stop();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, host_low_rail_sense, current_sense_input, power_permit} = '0;
        {ejector_open, bus_addr_match, bus_ack_drive, select_req, rail_sag} = '0;
        {host_high_rail_ok, aux_sense_a, aux_sense_b, host_reset_n, chip_select_n} = '1;
        reg_addr = '0;
        supply_level_strap = 1'b1;
        reg_wdata = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({26'h0, gate_drive_low_rail, gate_drive_high_rail, card_reset, card_reset_n,
               card_healthy_n, fault_n}, 32'h0B);
        t_regs();
        t_power();
        t_card();
        t_hrst();
        t_eject();
        t_breaker();
        t_wdog();
        report_and_stop();
    end

    // Hang guard: the full sequence needs about 75k cycles
    initial begin
        #(95000 * 10);
        bad_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
